// File: core/ldc_cmd_core.sv
`timescale 1ns/1ps
// Overview of operation
// - binary scroll: mode, start, endlo, endmsb, count
// - binary scroll end is nine bits
// - other scroll fields decode as gray mode
// - duty code N gives 1/(4(N+1))
// - duty resets to 1/132
// - start block k begins at line 4k
// - start block resets to zero
// - driven lines wrap past last common line
// - partial on/off by command bit zero
// - partial set: start line then line count
// - partial display keeps duty setting
// - rmw saves column, reads hold column
// - end leaves rmw, restores saved column
// - display mode gray or binary, gray at reset
module ldc_cmd_core (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // host byte port
  input wire logic wr_i,
  input wire ldc_pkg::ldc_host_byte_t byte_i,
  // display data access from the rest of the decoder
  input wire logic ddram_wr_i,
  input wire logic ddram_rd_i,
  input wire logic col_load_i,
  input wire logic [7:0] col_load_val_i,
  // settings
  output logic binary_mode_o,
  output logic [5:0] duty_o,
  output logic [5:0] block_o,
  output ldc_pkg::ldc_scroll_t scroll_o,
  output ldc_pkg::ldc_partial_t partial_o,
  output logic rmw_o,
  // derived state
  output logic [7:0] col_addr_o,
  output logic [8:0] com_first_o,
  output logic [8:0] com_last_o
);

  function automatic ldc_pkg::ldc_state_t decode_cmd(input logic [7:0] b);
    case (b)
      ldc_pkg::CMD_AREA_SCROLL: decode_cmd = ldc_pkg::ST_SCROLL;
      ldc_pkg::CMD_DUTY_SET: decode_cmd = ldc_pkg::ST_DUTY;
      ldc_pkg::CMD_PART_SET: decode_cmd = ldc_pkg::ST_PART;
      ldc_pkg::CMD_DISP_MODE: decode_cmd = ldc_pkg::ST_DMODE;
      default: decode_cmd = ldc_pkg::ST_IDLE;
    endcase
  endfunction : decode_cmd

  function automatic logic [2:0] last_idx(input ldc_pkg::ldc_state_t s,
                                          input logic bin);
    case (s)
      ldc_pkg::ST_SCROLL: begin
        last_idx = bin ? ldc_pkg::IDX_CNT_BIN : ldc_pkg::IDX_CNT_GRAY;
      end
      ldc_pkg::ST_DUTY: last_idx = ldc_pkg::IDX_BLOCK;
      ldc_pkg::ST_PART: last_idx = ldc_pkg::IDX_PCOUNT;
      default: last_idx = 3'h0;
    endcase
  endfunction : last_idx

  ldc_pkg::ldc_state_t state_reg;
  logic [2:0] pidx_reg;
  logic scroll_bin_reg;
  logic cmd_wr;
  logic prm_wr;
  logic [7:0] d;
  logic rmw_enter;
  logic rmw_leave;

  // byte classification by the select pin
  assign cmd_wr = wr_i && !byte_i.cds;
  assign prm_wr = wr_i && byte_i.cds && state_reg != ldc_pkg::ST_IDLE;
  assign d = byte_i.data;
  assign rmw_enter = cmd_wr && d == ldc_pkg::CMD_RMW;
  assign rmw_leave = cmd_wr && d == ldc_pkg::CMD_RMW_END && rmw_o;

  // pending command and parameter position
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ldc_pkg::ST_IDLE;
      pidx_reg <= 3'h0;
    end else if (cmd_wr) begin
      state_reg <= decode_cmd(d);
      pidx_reg <= 3'h0;
    end else if (prm_wr) begin
      if (pidx_reg == last_idx(state_reg, scroll_bin_reg)) begin
        state_reg <= ldc_pkg::ST_IDLE;
        pidx_reg <= 3'h0;
      end else begin
        pidx_reg <= 3'(pidx_reg + 3'h1);
      end
    end
  end

  // scroll layout is fixed by the mode in force at the command byte
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scroll_bin_reg <= 1'b0;
    end else if (cmd_wr) begin
      scroll_bin_reg <= binary_mode_o;
    end
  end

  // display mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      binary_mode_o <= 1'b0;
    end else if (prm_wr && state_reg == ldc_pkg::ST_DMODE) begin
      binary_mode_o <= (d[1:0] == ldc_pkg::DMODE_BINARY);
    end
  end

  // area scroll fields
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scroll_o <= '0;
    end else if (prm_wr && state_reg == ldc_pkg::ST_SCROLL) begin
      case (pidx_reg)
        ldc_pkg::IDX_MODE: scroll_o.mode <= d[1:0];
        ldc_pkg::IDX_START: scroll_o.start_line <= d;
        ldc_pkg::IDX_END_LO: begin
          scroll_o.end_line[7:0] <= d;
          if (!scroll_bin_reg) begin
            scroll_o.end_line[ldc_pkg::END_MSB_BIT] <= 1'b0;
          end
        end
        ldc_pkg::IDX_END_MSB: begin
          if (scroll_bin_reg) begin
            scroll_o.end_line[ldc_pkg::END_MSB_BIT] <= d[0];
          end else begin
            scroll_o.line_count <= d;
          end
        end
        ldc_pkg::IDX_CNT_BIN: scroll_o.line_count <= d;
        default: scroll_o <= scroll_o;
      endcase
    end
  end

  // duty and start block
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_o <= ldc_pkg::DUTY_RST;
      block_o <= ldc_pkg::BLOCK_RST;
    end else if (prm_wr && state_reg == ldc_pkg::ST_DUTY) begin
      if (pidx_reg == ldc_pkg::IDX_DUTY) begin
        duty_o <= d[ldc_pkg::SIX_BIT_W-1:0];
      end else begin
        block_o <= d[ldc_pkg::SIX_BIT_W-1:0];
      end
    end
  end

  // partial display
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      partial_o <= '0;
    end else if (cmd_wr && d[7:1] == ldc_pkg::CMD_PART_ONOFF) begin
      partial_o.enable <= d[0];
    end else if (prm_wr && state_reg == ldc_pkg::ST_PART) begin
      if (pidx_reg == ldc_pkg::IDX_PSTART) begin
        partial_o.start_line <= d;
      end else begin
        partial_o.line_count <= d;
      end
    end
  end

  // read-modify-write mode flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rmw_o <= 1'b0;
    end else if (rmw_enter) begin
      rmw_o <= 1'b1;
    end else if (rmw_leave) begin
      rmw_o <= 1'b0;
    end
  end

  // a column load during rmw is the host's fault and is obeyed
  ldc_col_ctr u_col (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(col_load_i),
    .load_val_i(col_load_val_i),
    .wr_i(ddram_wr_i),
    .rd_i(ddram_rd_i),
    .hold_rd_i(rmw_o),
    .save_i(rmw_enter && !rmw_o),
    .restore_i(rmw_leave),
    .col_o(col_addr_o)
  );

  // block and duty are set only by their own command
  ldc_com_window u_com (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .duty_i(duty_o),
    .block_i(block_o),
    .com_first_o(com_first_o),
    .com_last_o(com_last_o)
  );

  AST_RESET_DUTY: assert property (@(posedge mclk_i)
    $rose(rst_n_i) |-> duty_o == 6'h20 && block_o == 6'h00)
    else $error("duty or block wrong after reset");

  AST_SCROLL_MSB: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_SCROLL && scroll_bin_reg
      && pidx_reg == 3'h3)
      |=> scroll_o.end_line[8] == $past(d[0]) && state_reg == $past(state_reg))
    else $error("binary scroll end msb not taken");

  AST_SCROLL_GRAY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_SCROLL && !scroll_bin_reg
      && pidx_reg == 3'h2)
      |=> scroll_o.end_line == {1'b0, $past(d)})
    else $error("gray scroll end line wrong");

  AST_SCROLL_LAST: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_SCROLL && scroll_bin_reg
      && pidx_reg == 3'h4)
      |=> scroll_o.line_count == $past(d) && state_reg == ldc_pkg::ST_IDLE)
    else $error("binary scroll count or sequence end wrong");

  AST_DUTY_BLOCK: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_DUTY && pidx_reg == 3'h0)
      ##1 (prm_wr && byte_i.cds)
      |=> duty_o == $past(duty_o) && block_o == $past(d[5:0]))
    else $error("duty pair not stored in order");

  AST_PART_ONOFF: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (cmd_wr && d[7:1] == 7'h4B) |=> partial_o.enable == $past(d[0]))
    else $error("partial enable bit wrong");

  AST_PART_KEEP_DUTY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_PART)
      |=> $stable(duty_o) && $stable(block_o))
    else $error("partial setting changed duty");

  AST_PART_COUNT: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_PART && pidx_reg == 3'h1)
      |=> partial_o.line_count == $past(d) && state_reg == ldc_pkg::ST_IDLE)
    else $error("partial line count not taken");

  AST_RMW_HOLD: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rmw_o && ddram_rd_i && !ddram_wr_i && !col_load_i && !cmd_wr)
      |=> $stable(col_addr_o))
    else $error("read moved column during rmw");

  AST_RMW_ENTER: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rmw_enter || (rmw_o && !rmw_leave)) |=> rmw_o)
    else $error("rmw mode dropped without end");

  AST_PARAM_IDLE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (wr_i && byte_i.cds && state_reg == ldc_pkg::ST_IDLE)
      |=> $stable(duty_o) && $stable(scroll_o) && $stable(partial_o))
    else $error("stray parameter changed settings");

  AST_SCROLL_MODE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_SCROLL && pidx_reg == 3'h0)
      |=> scroll_o.mode == $past(d[1:0]))
    else $error("scroll mode not taken");

  AST_SCROLL_START: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_SCROLL && pidx_reg == 3'h1)
      |=> scroll_o.start_line == $past(d))
    else $error("scroll start line not taken");

  AST_DUTY_STORE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_DUTY && pidx_reg == 3'h0)
      |=> duty_o == $past(d[5:0]))
    else $error("duty code not taken");

  AST_PART_START: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_PART && pidx_reg == 3'h0)
      |=> partial_o.start_line == $past(d))
    else $error("partial start line not taken");

  AST_DMODE_SET: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (prm_wr && state_reg == ldc_pkg::ST_DMODE)
      |=> binary_mode_o == ($past(d[1:0]) == ldc_pkg::DMODE_BINARY))
    else $error("display mode parameter not taken");

  AST_CMD_RESTART: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    cmd_wr |=> pidx_reg == 3'h0)
    else $error("command byte did not restart decoding");

  AST_RMW_LEAVE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    rmw_leave |=> !rmw_o)
    else $error("end command did not leave rmw");

endmodule : ldc_cmd_core

// File: core/ldc_col_ctr.sv
`timescale 1ns/1ps
module ldc_col_ctr (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // column control
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic hold_rd_i,
  input wire logic save_i,
  input wire logic restore_i,
  // column address
  output logic [7:0] col_o
);

  function automatic logic [7:0] next_col(input logic [7:0] c);
    next_col = (c == ldc_pkg::COL_LAST) ? 8'h00 : 8'(c + 8'h01);
  endfunction : next_col

  logic [7:0] save_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      save_reg <= ldc_pkg::COL_RST;
    end else if (save_i) begin
      save_reg <= col_o;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_o <= ldc_pkg::COL_RST;
    end else if (restore_i) begin
      col_o <= save_reg;
    end else if (load_i) begin
      col_o <= load_val_i;
    end else if (wr_i) begin
      col_o <= next_col(col_o);
    end else if (rd_i && !hold_rd_i) begin
      col_o <= next_col(col_o);
    end
  end

  AST_RMW_RESTORE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    restore_i |=> col_o == $past(save_reg))
    else $error("column not restored on end");

  AST_WR_ADVANCE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (wr_i && !load_i && !restore_i && col_o != ldc_pkg::COL_LAST)
      |=> col_o == 8'($past(col_o) + 8'h01))
    else $error("data write did not advance column");

endmodule : ldc_col_ctr

// File: core/ldc_com_window.sv
`timescale 1ns/1ps
module ldc_com_window (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // settings
  input wire logic [5:0] duty_i,
  input wire logic [5:0] block_i,
  // driven common range
  output logic [8:0] com_first_o,
  output logic [8:0] com_last_o
);

  function automatic logic [8:0] wrap_com(input logic [9:0] line);
    logic [9:0] lim;
    lim = {1'b0, ldc_pkg::COM_LINES};
    if (line >= lim) begin
      wrap_com = 9'(line - lim);
    end else begin
      wrap_com = line[8:0];
    end
  endfunction : wrap_com

  logic [9:0] first;
  logic [9:0] last_raw;
  assign first = {2'h0, block_i, 2'h0};
  assign last_raw = first + {2'h0, duty_i, 2'h3};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_first_o <= 9'h000;
      com_last_o <= 9'(ldc_pkg::COM_LINES - 9'h001);
    end else begin
      com_first_o <= wrap_com(first);
      com_last_o <= wrap_com(last_raw);
    end
  end

  AST_COM_WRAP: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (duty_i <= 6'h20 && block_i <= 6'h20) |=> (com_last_o < 9'h084))
    else $error("common range does not wrap");

endmodule : ldc_com_window

// File: include/ldc_pkg.sv
package ldc_pkg;

  // command codes, taken with cmd_data_select low
  localparam logic [7:0] CMD_AREA_SCROLL = 8'h10;
  localparam logic [7:0] CMD_DISP_MODE = 8'h66;
  localparam logic [7:0] CMD_DUTY_SET = 8'h6D;
  localparam logic [6:0] CMD_PART_ONOFF = 7'h4B;
  localparam logic [7:0] CMD_PART_SET = 8'h32;
  localparam logic [7:0] CMD_RMW = 8'hE0;
  localparam logic [7:0] CMD_RMW_END = 8'hEE;

  // parameter byte positions
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_START = 3'h1;
  localparam logic [2:0] IDX_END_LO = 3'h2;
  localparam logic [2:0] IDX_END_MSB = 3'h3;
  localparam logic [2:0] IDX_CNT_GRAY = 3'h3;
  localparam logic [2:0] IDX_CNT_BIN = 3'h4;
  localparam logic [2:0] IDX_DUTY = 3'h0;
  localparam logic [2:0] IDX_BLOCK = 3'h1;
  localparam logic [2:0] IDX_PSTART = 3'h0;
  localparam logic [2:0] IDX_PCOUNT = 3'h1;
  localparam logic [2:0] IDX_DMODE = 3'h0;

  // field positions
  localparam int unsigned END_MSB_BIT = 8;
  localparam int unsigned SIX_BIT_W = 6;
  localparam logic [1:0] DMODE_BINARY = 2'h1;

  // reset values
  localparam logic [5:0] DUTY_RST = 6'h20;
  localparam logic [5:0] BLOCK_RST = 6'h00;
  localparam logic [1:0] DMODE_RST = 2'h0;
  localparam logic [7:0] COL_RST = 8'h00;

  // common line and column geometry
  localparam logic [8:0] COM_LINES = 9'h084;
  localparam logic [7:0] COL_LAST = 8'h9F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SCROLL = 3'b001,
    ST_DUTY = 3'b010,
    ST_PART = 3'b011,
    ST_DMODE = 3'b100
  } ldc_state_t;

  typedef struct packed {
    logic cds;
    logic [7:0] data;
  } ldc_host_byte_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] start_line;
    logic [8:0] end_line;
    logic [7:0] line_count;
  } ldc_scroll_t;

  typedef struct packed {
    logic enable;
    logic [7:0] start_line;
    logic [7:0] line_count;
  } ldc_partial_t;

endpackage : ldc_pkg

// File: verif/ldc_host_model.sv
`timescale 1ns/1ps
module ldc_host_model (
  // clock
  input wire logic mclk_i,
  // host byte port
  output logic wr_o,
  output ldc_pkg::ldc_host_byte_t byte_o
);
  initial begin
    wr_o = 1'b0;
    byte_o = 9'h000;
  end

  // strobe stays up so a following byte can go back to back
  task put(input logic cds, input logic [7:0] data);
    wr_o <= 1'b1;
    byte_o <= {cds, data};
    @(posedge mclk_i);
  endtask : put

  // released data lines toggle instead of holding the last byte
  task idle(input int n);
    wr_o <= 1'b0;
    byte_o.data <= ~byte_o.data;
    repeat (n) @(posedge mclk_i);
  endtask : idle

  // command byte then np parameters; gap 0 sends them back to back
  task send(input logic [7:0] c, input logic [7:0] p [0:4], input int np,
            input int gap);
    put(1'b0, c);
    for (int i = 0; i < np; i++) begin
      if (gap > 0) idle(gap);
      put(1'b1, p[i]);
    end
    idle(4);
  endtask : send
endmodule : ldc_host_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk_i, rst_n_i, wr_i, ddram_wr_i, ddram_rd_i, col_load_i;
  ldc_pkg::ldc_host_byte_t byte_i;
  logic [7:0] col_load_val_i, col_addr_o, a, b, c, d;
  logic binary_mode_o, rmw_o;
  logic [5:0] duty_o, block_o;
  ldc_pkg::ldc_scroll_t scroll_o;
  ldc_pkg::ldc_partial_t partial_o;
  logic [8:0] com_first_o, com_last_o;
  int n_fail, total_checks, seed, n, k;

  ldc_host_model ldc_host_model_i (.mclk_i(mclk_i), .wr_o(wr_i),
    .byte_o(byte_i));
  ldc_cmd_core ldc_cmd_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wr_i(wr_i), .byte_i(byte_i), .ddram_wr_i(ddram_wr_i),
    .ddram_rd_i(ddram_rd_i), .col_load_i(col_load_i),
    .col_load_val_i(col_load_val_i), .binary_mode_o(binary_mode_o),
    .duty_o(duty_o), .block_o(block_o), .scroll_o(scroll_o),
    .partial_o(partial_o), .rmw_o(rmw_o), .col_addr_o(col_addr_o),
    .com_first_o(com_first_o), .com_last_o(com_last_o));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task chk_val(input string name, input logic [31:0] exp,
               input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk_val

  task chk_bit(input string name, input logic exp, input logic got);
    chk_val(name, {31'h00000000, exp}, {31'h00000000, got});
  endtask : chk_bit

  function automatic logic [8:0] exp_last(input int nn, input int kk);
    int l;
    l = 4 * kk + 4 * (nn + 1) - 1;
    if (l >= 132) l = l - 132;
    return l[8:0];
  endfunction : exp_last

  task strobe(input int kind, input logic [7:0] v);
    case (kind)
      0: begin
        col_load_i <= 1'b1;
        col_load_val_i <= v;
      end
      1: ddram_wr_i <= 1'b1;
      default: ddram_rd_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    col_load_i <= 1'b0;
    ddram_wr_i <= 1'b0;
    ddram_rd_i <= 1'b0;
    col_load_val_i <= ~v;
    @(posedge mclk_i);
  endtask : strobe

  // one chip here, so every chip holds this same duty
  task duty(input int nn, input int kk);
    ldc_host_model_i.send(ldc_pkg::CMD_DUTY_SET,
      '{nn[7:0], kk[7:0], 8'h00, 8'h00, 8'h00}, 2, 0);
    chk_val("duty", nn, duty_o);
    chk_val("block", kk, block_o);
    chk_val("com_first", 4 * kk, com_first_o);
    chk_val("com_last", exp_last(nn, kk), com_last_o);
  endtask : duty

  task results;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    results();
  end

  initial begin
    seed = 91597;
    n_fail = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    ddram_wr_i = 1'b0;
    ddram_rd_i = 1'b0;
    col_load_i = 1'b0;
    col_load_val_i = 8'h00;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    chk_bit("binary_mode", 1'b0, binary_mode_o);
    chk_val("duty", 32'h20, duty_o);
    chk_val("block", 32'h0, block_o);
    chk_val("com_last", 32'h83, com_last_o);
    chk_bit("rmw", 1'b0, rmw_o);
    // block is only a window position, never a scroll
    duty(0, 32);
    duty(32, 1);
    duty(16, 26);
    duty(21, 1);
    for (int i = 0; i < 10; i++) begin
      n = {$random(seed)} % 33;
      k = {$random(seed)} % 33;
      duty(n, k);
    end
    ldc_host_model_i.put(1'b1, 8'h05);
    ldc_host_model_i.idle(3);
    chk_val("duty", n, duty_o);
    for (int i = 0; i < 3; i++) begin
      ldc_host_model_i.send({ldc_pkg::CMD_PART_ONOFF, ~i[0]},
        '{default: 8'h00}, 0, 0);
      chk_bit("partial_en", ~i[0], partial_o.enable);
      // start plus count kept within 132 lines
      a = (i == 0) ? 8'h00 : 8'({$random(seed)} % 132);
      b = (i == 0) ? 8'h84 : 8'(1 + {$random(seed)} % (132 - a));
      ldc_host_model_i.send(ldc_pkg::CMD_PART_SET,
        '{a, b, 8'h00, 8'h00, 8'h00}, 2, i);
      chk_val("partial_start", a, partial_o.start_line);
      chk_val("partial_count", b, partial_o.line_count);
      chk_val("duty", n, duty_o);
    end
    // binary first, so the gray pass must clear a set end line msb
    for (int bm = 1; bm >= 0; bm--) begin
      ldc_host_model_i.send(ldc_pkg::CMD_DISP_MODE,
        '{bm[0] ? 8'h01 : 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 1, bm);
      chk_bit("binary_mode", bm[0], binary_mode_o);
      for (int m = 0; m < 4; m++) begin
        a = 8'($random(seed));
        b = (m == 3) ? 8'h07 : 8'($random(seed));
        c = 8'($random(seed));
        d = (m == 3) ? 8'hFF : 8'($random(seed));
        // gray takes the count fourth and clears the end line msb
        if (bm == 0) begin
          ldc_host_model_i.send(ldc_pkg::CMD_AREA_SCROLL,
            '{{c[7:2], m[1:0]}, a, b, c, d}, 4, m % 2);
          d = 8'h00;
        end else begin
          ldc_host_model_i.send(ldc_pkg::CMD_AREA_SCROLL,
            '{{c[7:2], m[1:0]}, a, b, d, c}, 5, m % 2);
        end
        chk_val("scroll", {5'h00, m[1:0], a, d[0], b, c},
                scroll_o);
      end
    end
    strobe(0, 8'h9E);
    chk_val("col", 32'h9E, col_addr_o);
    strobe(1, 8'h00);
    chk_val("col", 32'h9F, col_addr_o);
    strobe(2, 8'h00);
    chk_val("col", 32'h00, col_addr_o);
    strobe(0, 8'h40);
    // no column load while the mode is active
    ldc_host_model_i.send(ldc_pkg::CMD_RMW, '{default: 8'h00}, 0, 0);
    chk_bit("rmw", 1'b1, rmw_o);
    repeat (2) strobe(2, 8'h00);
    chk_val("col", 32'h40, col_addr_o);
    repeat (3) strobe(1, 8'h00);
    chk_val("col", 32'h43, col_addr_o);
    ldc_host_model_i.send(ldc_pkg::CMD_RMW_END, '{default: 8'h00}, 0, 0);
    chk_bit("rmw", 1'b0, rmw_o);
    chk_val("col", 32'h40, col_addr_o);
    // mid-run reset with binary and rmw set: all settings return
    ldc_host_model_i.send(ldc_pkg::CMD_DISP_MODE, '{default: 8'h01}, 1, 0);
    ldc_host_model_i.send(ldc_pkg::CMD_RMW, '{default: 8'h00}, 0, 0);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk_bit("binary_mode", 1'b0, binary_mode_o);
    chk_bit("rmw", 1'b0, rmw_o);
    chk_val("duty", 32'h20, duty_o);
    chk_val("block", 32'h0, block_o);
    chk_val("col", 32'h0, col_addr_o);
    chk_val("partial", 32'h0, partial_o);
    chk_val("scroll", 32'h0, scroll_o);
    chk_val("com_first", 32'h0, com_first_o);
    chk_val("com_last", 32'h83, com_last_o);
    duty(8, 4);
    results();
  end
endmodule : tb_top
